// file: isv_ctrl.sv
`timescale 1ns/100ps
module isv_ctrl
	import isv_pkg::*;
#(
	parameter int NSRC = PERIPH_COUNT
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire isv_cpu_ev_t cpu_ev,
	input wire logic nmi_n,
	input wire logic [NSRC-1:0] periph_req,
	input wire logic global_enable,
	input wire logic [2:0] current_priority_level,
	input wire logic cpu_ready,
	output isv_accept_t accept,
	output logic accept_valid
);
	// =====================================================================
	// registers
	logic [19:0] vector_base_pointer;
	logic [19:0] match_address_reg [2];
	logic [5:0] ctrl;
	logic [NSRC-1:0] request_pending_bit;
	logic [2:0] source_priority_field [NSRC];
	logic [7:0] bkpt_mark;
	logic nmi_q;
	logic [5:0] pend_special;
	logic [5:0] trap_num_q;

	// =====================================================================
	// apb decode; zero wait states, unmapped reads zero with slverr
	wire logic wr = psel & penable & pwrite;
	wire logic rd = psel & penable & ~pwrite;
	wire logic hit_any = paddr inside {REG_BASE, REG_MATCH0, REG_MATCH1, REG_CTRL,
		REG_PEND, REG_PRIO_LO, REG_PRIO_HI, REG_ACCEPT, REG_BRKMARK};
	logic [31:0] next_prdata;
	logic [31:0] prio_lo_word;
	logic [31:0] prio_hi_word;

	// pack priority fields, four bits per source, sources 0-7 then 8-15
	always_comb begin
		prio_lo_word = '0;
		prio_hi_word = '0;
		for (int i = 0; i < 8; i++) begin
			prio_lo_word[i*4 +: 3] = source_priority_field[i];
			prio_hi_word[i*4 +: 3] = source_priority_field[i+8];
		end
	end

	// read mux; sources 16-27 have no priority word and stay at level 0
	always_comb begin
		case (paddr)
			REG_BASE: next_prdata = {12'h000, vector_base_pointer};
			REG_MATCH0: next_prdata = {12'h000, match_address_reg[0]};
			REG_MATCH1: next_prdata = {12'h000, match_address_reg[1]};
			REG_CTRL: next_prdata = {26'h0000000, ctrl};
			REG_PEND: next_prdata = 32'(request_pending_bit);
			REG_PRIO_LO: next_prdata = prio_lo_word;
			REG_PRIO_HI: next_prdata = prio_hi_word;
			REG_ACCEPT: next_prdata = accept[31:0]; // source code does not fit the word
			REG_BRKMARK: next_prdata = {24'h000000, bkpt_mark};
			default: next_prdata = 32'h00000000;
		endcase
	end

	// =====================================================================
	// register writes; pending bits: hardware set wins over software clear
	wire logic [NSRC-1:0] pend_clr_sw = (wr && paddr == REG_PEND) ?
		~pwdata[NSRC-1:0] : '0;
	logic [NSRC-1:0] pend_clr_hw;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			vector_base_pointer <= 20'h00000;
			match_address_reg[0] <= 20'h00000;
			match_address_reg[1] <= 20'h00000;
			ctrl <= 6'h00;
			bkpt_mark <= 8'h00;
		end else if (wr) begin
			case (paddr)
				REG_BASE: vector_base_pointer <= pwdata[19:0];
				REG_MATCH0: match_address_reg[0] <= pwdata[19:0];
				REG_MATCH1: match_address_reg[1] <= pwdata[19:0];
				REG_CTRL: ctrl <= pwdata[5:0];
				REG_BRKMARK: bkpt_mark <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// priority fields; 000 keeps a source off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NSRC; i++)
				source_priority_field[i] <= 3'h0;
		end else if (wr) begin
			for (int i = 0; i < 8; i++) begin
				if (paddr == REG_PRIO_LO)
					source_priority_field[i] <= pwdata[i*4 +: 3];
				if (paddr == REG_PRIO_HI)
					source_priority_field[i+8] <= pwdata[i*4 +: 3];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			request_pending_bit <= '0;
		end else begin
			request_pending_bit <= (request_pending_bit & ~pend_clr_sw & ~pend_clr_hw)
				| periph_req;
		end
	end

	// =====================================================================
	// special and software events latch until taken
	wire logic nmi_fall = nmi_q & ~nmi_n;
	wire logic match_hit = cpu_ev.fetch & (
		(ctrl[CTRL_MEN0] && cpu_ev.fetch_addr == match_address_reg[0]) ||
		(ctrl[CTRL_MEN1] && cpu_ev.fetch_addr == match_address_reg[1]));
	// bit order: nmi, wdt, dbg, step, match, sw
	wire logic [5:0] special_in = {nmi_fall, cpu_ev.wdt, cpu_ev.dbg, cpu_ev.step,
		match_hit, cpu_ev.undef_op | (cpu_ev.into & cpu_ev.overflow_flag) | cpu_ev.bkpt |
		cpu_ev.trap};
	logic [5:0] special_take;
	isv_src_t sw_kind;
	isv_src_t next_sw_kind;

	// which software instruction is waiting; only one per instruction
	always_comb begin
		if (cpu_ev.undef_op)
			next_sw_kind = ISV_SRC_UNDEF;
		else if (cpu_ev.into && cpu_ev.overflow_flag)
			next_sw_kind = ISV_SRC_OVF;
		else if (cpu_ev.bkpt)
			next_sw_kind = ISV_SRC_BKPT;
		else if (cpu_ev.trap)
			next_sw_kind = ISV_SRC_TRAP;
		else
			next_sw_kind = sw_kind;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nmi_q <= 1'b1;
			pend_special <= 6'h00;
			sw_kind <= ISV_SRC_NONE;
			trap_num_q <= 6'h00;
		end else begin
			nmi_q <= nmi_n;
			pend_special <= (pend_special & ~special_take) | special_in;
			sw_kind <= next_sw_kind;
			if (cpu_ev.trap)
				trap_num_q <= cpu_ev.trap_num;
		end
	end

	// =====================================================================
	// maskable arbitration: highest level, ties to lowest number
	logic [2:0] best_lvl;
	logic [4:0] best_idx;
	logic best_ok;
	always_comb begin
		best_lvl = 3'h0;
		best_idx = 5'h00;
		best_ok = 1'b0;
		for (int i = 0; i < NSRC; i++) begin
			if (request_pending_bit[i] && source_priority_field[i] > current_priority_level
				&& source_priority_field[i] > best_lvl) begin
				best_lvl = source_priority_field[i];
				best_idx = 5'(i);
				best_ok = 1'b1;
			end
		end
		best_ok = best_ok & global_enable;
	end

	// =====================================================================
	// vector selection; specials ignore enable and level
	isv_accept_t next_accept;
	logic next_valid;
	wire logic bkpt_reloc = (bkpt_mark == BKPT_REDIRECT_MARK);
	function automatic logic [19:0] reloc(input logic [19:0] base, input logic [5:0] n);
		reloc = base + {12'h000, n, 2'b00};
	endfunction : reloc
	function automatic logic [19:0] fixed(input isv_src_t s);
		fixed = FIXED_BASE + ENTRY_BYTES * 20'(s - ISV_SRC_UNDEF);
	endfunction : fixed

	always_comb begin
		next_accept = '0;
		next_accept.odd_base = vector_base_pointer[0];
		next_valid = 1'b0;
		special_take = 6'h00;
		pend_clr_hw = '0;
		if (pend_special[5]) begin
			next_accept.src = ISV_SRC_NMI;
			next_accept.vec_addr = NMI_VEC;
			next_accept.new_level = LEVEL_NMI_WDT;
			next_accept.set_level = 1'b1;
			special_take = 6'h20;
		end else if (pend_special[4]) begin
			next_accept.src = ISV_SRC_WDT;
			next_accept.vec_addr = fixed(ISV_SRC_WDT);
			next_accept.new_level = LEVEL_NMI_WDT;
			next_accept.set_level = 1'b1;
			special_take = 6'h10;
		end else if (pend_special[3]) begin
			next_accept.src = ISV_SRC_DBG;
			next_accept.vec_addr = fixed(ISV_SRC_DBG);
			special_take = 6'h08;
		end else if (pend_special[2]) begin
			next_accept.src = ISV_SRC_STEP;
			next_accept.vec_addr = fixed(ISV_SRC_STEP);
			special_take = 6'h04;
		end else if (pend_special[1]) begin
			next_accept.src = ISV_SRC_MATCH;
			next_accept.vec_addr = fixed(ISV_SRC_MATCH);
			special_take = 6'h02;
		end else if (pend_special[0]) begin
			next_accept.src = sw_kind;
			special_take = 6'h01;
			if (sw_kind == ISV_SRC_TRAP) begin
				next_accept.number = trap_num_q;
				next_accept.vec_addr = reloc(vector_base_pointer, trap_num_q);
				next_accept.clear_stack_sel = trap_num_q < TRAP_USP_FIRST;
			end else if (sw_kind == ISV_SRC_BKPT && bkpt_reloc) begin
				next_accept.vec_addr = reloc(vector_base_pointer, 6'h00);
				next_accept.clear_stack_sel = 1'b1;
			end else begin
				next_accept.vec_addr = fixed(sw_kind);
				next_accept.clear_stack_sel = 1'b1;
			end
		end else if (best_ok) begin
			next_accept.src = ISV_SRC_PERIPH;
			next_accept.number = 6'(best_idx) + 6'(PERIPH_FIRST);
			next_accept.vec_addr = reloc(vector_base_pointer, next_accept.number);
			next_accept.new_level = best_lvl;
			next_accept.set_level = 1'b1;
			next_accept.clear_stack_sel = 1'b1;
			pend_clr_hw[best_idx] = 1'b1;
		end
		next_valid = next_accept.src != ISV_SRC_NONE;
		if (!cpu_ready) begin
			next_valid = 1'b0;
			special_take = 6'h00;
			pend_clr_hw = '0;
		end
	end

	// outputs registered; one-cycle accept pulse
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			accept <= '0;
			accept_valid <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			accept <= next_valid ? next_accept : accept;
			accept_valid <= next_valid;
			prdata <= (psel & ~penable & ~pwrite) ? next_prdata : prdata;
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit_any;
		end
	end
endmodule : isv_ctrl

// file: isv_pkg.sv
// Summary of operation
// - every vector entry is four bytes holding the handler start address
// - fixed vectors sit from fffdc to fffff, independent of the base pointer
// - fixed slots: undefined, overflow, breakpoint, match, step, watchdog, debug, nmi, reset
// - breakpoint uses relocatable entry 0 when byte fffe7 reads ff; the code tests the bkpt_mark register (REG_BRKMARK) for ff
// - relocatable table is 256 bytes at base, entry at base plus four times number
// - software trap accepts numbers 0 to 63 through the relocatable table
// - entries 4 to 31 serve peripherals; a trap with same number hits same handler
// - traps 0 to 31 push stack-select flag, clear it, restore on return; here they only raise clear_stack_sel, and nothing pushes or restores the flag
// - traps 32 to 63 leave stack-select flag unchanged
// - undefined opcode instruction always raises its interrupt
// - overflow trap raises interrupt only while overflow flag is 1
// - breakpoint instruction raises the breakpoint interrupt
// - nmi request is made on a high-to-low pin transition
// - address match fires before an instruction at an enabled match address
// - traps and special interrupts ignore global enable and priority
// - peripheral requests obey global enable and programmable priority
// - even base pointer gives the faster sequence; software should load even
// - entry 0 and traps 32 to 63 cannot be disabled by global enable
// - entry 9 and entries 6, 7 follow source select bits; ctrl bits 2 to 4 are only stored here and steer no entry
// - in i2c mode entries carry nack/ack and start/stop detection; ctrl bit 5 (CTRL_I2C) is only stored here and changes no entry
// - on acceptance the handler address from the matching entry loads the pc; the sequencer stand-in loads the entry address (vec_addr) itself
// - maskable accepted only with enable 1, pending 1, priority above current level
// - priority field 000 disables; 001 to 111 are levels 1 to 7
package isv_pkg;
	// =====================================================================
	// address map
	localparam logic [19:0] FIXED_BASE = 20'hfffdc;
	localparam logic [19:0] BKPT_REDIRECT_ADDR = 20'hfffe7;
	localparam logic [7:0] BKPT_REDIRECT_MARK = 8'hff;
	localparam logic [19:0] NMI_VEC = 20'hffff8;
	localparam logic [19:0] RESET_VEC = 20'hffffc;
	localparam logic [19:0] ENTRY_BYTES = 20'h00004;
	localparam int PERIPH_FIRST = 4;
	localparam int PERIPH_COUNT = 28;
	localparam logic [5:0] TRAP_USP_FIRST = 6'h20;
	localparam logic [2:0] LEVEL_NMI_WDT = 3'h7;
	// apb register offsets
	localparam logic [7:0] REG_BASE = 8'h00;
	localparam logic [7:0] REG_MATCH0 = 8'h04;
	localparam logic [7:0] REG_MATCH1 = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h0c;
	localparam logic [7:0] REG_PEND = 8'h10;
	localparam logic [7:0] REG_PRIO_LO = 8'h14;
	localparam logic [7:0] REG_PRIO_HI = 8'h18;
	localparam logic [7:0] REG_ACCEPT = 8'h1c;
	localparam logic [7:0] REG_BRKMARK = 8'h20;
	// ctrl bit positions
	localparam int CTRL_MEN0 = 0;
	localparam int CTRL_MEN1 = 1;
	localparam int CTRL_SEL_INT4 = 2;
	localparam int CTRL_SEL_U1 = 3;
	localparam int CTRL_SEL_U0 = 4;
	localparam int CTRL_I2C = 5;

	// source kinds
	typedef enum logic [3:0] {
		ISV_SRC_NONE = 4'h0,
		ISV_SRC_UNDEF = 4'h1,
		ISV_SRC_OVF = 4'h2,
		ISV_SRC_BKPT = 4'h3,
		ISV_SRC_MATCH = 4'h4,
		ISV_SRC_STEP = 4'h5,
		ISV_SRC_WDT = 4'h6,
		ISV_SRC_DBG = 4'h7,
		ISV_SRC_NMI = 4'h8,
		ISV_SRC_TRAP = 4'h9,
		ISV_SRC_PERIPH = 4'ha
	} isv_src_t;

	// one accepted request as handed to the sequencer
	typedef struct packed {
		isv_src_t src;
		logic [5:0] number;
		logic [19:0] vec_addr;
		logic [2:0] new_level;
		logic set_level;
		logic clear_stack_sel;
		logic odd_base;
	} isv_accept_t;

	// cpu-side events, one-cycle pulses
	typedef struct packed {
		logic undef_op;
		logic into;
		logic overflow_flag;
		logic bkpt;
		logic trap;
		logic [5:0] trap_num;
		logic step;
		logic wdt;
		logic dbg;
		logic fetch;
		logic [19:0] fetch_addr;
	} isv_cpu_ev_t;
endpackage : isv_pkg

// file: isv_ctrl_chk.sv
`timescale 1ns/100ps
// =========================================
// acceptance rule checker
module isv_ctrl_chk
	import isv_pkg::*;
#(
	parameter int NSRC = PERIPH_COUNT
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire isv_cpu_ev_t cpu_ev,
	input wire logic nmi_n,
	input wire logic [NSRC-1:0] periph_req,
	input wire logic global_enable,
	input wire logic [2:0] current_priority_level,
	input wire logic cpu_ready,
	input wire isv_accept_t accept,
	input wire logic accept_valid
);
	isv_src_t s;
	logic v;
	// short names keep the properties to one or two lines each
	assign s = accept.src;
	assign v = accept_valid;
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	AST_FIXED_SLOT: assert property (v && s inside {[ISV_SRC_UNDEF:ISV_SRC_NMI]}
		&& s != ISV_SRC_BKPT |-> accept.vec_addr == FIXED_BASE + ENTRY_BYTES * (20'(s) - 20'h1))
		else $error("fixed vector slot wrong");
	AST_BKPT_TAKEN: assert property (cpu_ev.bkpt |-> ##[2:20] (v && s == ISV_SRC_BKPT))
		else $error("breakpoint not accepted");
	AST_NMI_EDGE: assert property ($fell(nmi_n) |-> ##[2:20] (v && s == ISV_SRC_NMI))
		else $error("nmi edge not accepted");
	AST_TOP_LEVEL: assert property (v && s inside {ISV_SRC_NMI, ISV_SRC_WDT}
		|-> accept.set_level && accept.new_level == LEVEL_NMI_WDT)
		else $error("nmi or watchdog level wrong");
	AST_MASKED: assert property (v && s == ISV_SRC_PERIPH
		|-> $past(global_enable) && accept.new_level > $past(current_priority_level))
		else $error("masked peripheral accepted");
	AST_PERIPH_ENTRY: assert property (v && s == ISV_SRC_PERIPH
		|-> accept.new_level != 3'h0 && accept.number inside {[6'd4:6'd31]})
		else $error("peripheral entry or level wrong");
	AST_STACK_SEL: assert property (v && s == ISV_SRC_TRAP
		|-> accept.clear_stack_sel == (accept.number < TRAP_USP_FIRST))
		else $error("stack select wrong");
	AST_OVF_GATE: assert property (cpu_ev.into && !cpu_ev.overflow_flag
		|-> ##1 (!(v && s == ISV_SRC_OVF)) [*8])
		else $error("overflow raised without flag");
endmodule : isv_ctrl_chk

bind isv_ctrl isv_ctrl_chk #(.NSRC(NSRC)) u_chk (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cpu_ev(cpu_ev), .nmi_n(nmi_n),
	.periph_req(periph_req), .global_enable(global_enable),
	.current_priority_level(current_priority_level), .cpu_ready(cpu_ready),
	.accept(accept), .accept_valid(accept_valid));

// file: isv_seq_model.sv
`timescale 1ns/100ps
// =========================================
// sequencer stand-in
module isv_seq_model
	import isv_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic accept_valid,
	input wire isv_accept_t accept,
	output logic cpu_ready,
	output logic [19:0] pc
);
	logic [1:0] phase;
	// slow mode stalls three cycles in four so requests must wait pending
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 2'h0;
			pc <= 20'h0;
		end else begin
			phase <= phase + 2'h1;
			if (accept_valid) begin
				pc <= accept.vec_addr;
			end
		end
	end
	assign cpu_ready = rst_n && (!slow || phase == 2'h3);
endmodule : isv_seq_model

// file: tb_interrupt_source_vectoring.sv
`timescale 1ns/100ps
// =========================================
// bench
module tb_interrupt_source_vectoring;
	import isv_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	isv_cpu_ev_t cpu_ev = '0;
	logic nmi_n = 1'b1;
	logic [27:0] periph_req = 28'h0;
	logic global_enable = 1'b1;
	logic [2:0] cpl = 3'h0;
	logic cpu_ready;
	logic slow = 1'b0;
	isv_accept_t accept;
	logic accept_valid;
	logic [19:0] pc;
	logic [31:0] rdat;
	logic rerr;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	logic [5:0] tn [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
	localparam logic [19:0] BV = 20'h12344;
	always #2.5 clock = ~clock;
	isv_ctrl dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_ev(cpu_ev), .nmi_n(nmi_n), .periph_req(periph_req),
		.global_enable(global_enable), .current_priority_level(cpl),
		.cpu_ready(cpu_ready), .accept(accept), .accept_valid(accept_valid));
	isv_seq_model seq (.clock(clock), .rst_n(rst_n), .slow(slow),
		.accept_valid(accept_valid), .accept(accept), .cpu_ready(cpu_ready), .pc(pc));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one apb transfer; waits on pready, then lets an idle edge pass before the next setup
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic fire(input isv_cpu_ev_t e, input logic [27:0] m);
		cpu_ev <= e;
		periph_req <= m;
		@(posedge clock);
		cpu_ev <= '0;
		periph_req <= 28'h0;
	endtask : fire
	task automatic expect_acc(input string nm, input logic [19:0] va, input logic hit);
		logic got;
		got = 1'b0;
		for (int n = 0; n < 20 && !got; n++) begin
			@(posedge clock);
			got = (accept_valid === 1'b1);
		end
		chk(nm, {31'h0, hit}, {31'h0, got});
		if (hit && got) begin
			chk(nm, {12'h0, va}, {12'h0, accept.vec_addr});
			// the sequencer loads its pc on the edge that sees the pulse
			@(posedge clock);
			chk(nm, {12'h0, va}, {12'h0, pc});
		end
	endtask : expect_acc
	task automatic end_of_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	// hang guard well beyond the few hundred cycles the sequence needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		apb(1'b0, REG_BASE, 32'h0);
		chk("base reset", 32'h0, rdat);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, rerr});
		apb(1'b1, REG_BASE, {12'h0, BV});
		apb(1'b0, REG_BASE, 32'h0);
		chk("base", {12'h0, BV}, rdat);
		fire('{default: '0, undef_op: 1'b1}, 28'h0);
		expect_acc("und", 20'hfffdc, 1'b1);
		fire('{default: '0, into: 1'b1, overflow_flag: 1'b1}, 28'h0);
		expect_acc("ovf", 20'hfffe0, 1'b1);
		fire('{default: '0, into: 1'b1}, 28'h0);
		expect_acc("ovf clear", 20'h0, 1'b0);
		fire('{default: '0, bkpt: 1'b1}, 28'h0);
		expect_acc("brk", 20'hfffe4, 1'b1);
		fire('{default: '0, step: 1'b1}, 28'h0);
		expect_acc("step", 20'hfffec, 1'b1);
		fire('{default: '0, wdt: 1'b1}, 28'h0);
		expect_acc("wdt", 20'hffff0, 1'b1);
		fire('{default: '0, dbg: 1'b1}, 28'h0);
		expect_acc("dbg", 20'hffff4, 1'b1);
		apb(1'b1, REG_BRKMARK, 32'hff);
		fire('{default: '0, bkpt: 1'b1}, 28'h0);
		expect_acc("brk reloc", BV, 1'b1);
		apb(1'b1, REG_BRKMARK, 32'h0);
		global_enable <= 1'b0;
		foreach (tn[i]) begin
			fire('{default: '0, trap: 1'b1, trap_num: tn[i]}, 28'h0);
			expect_acc("trap", BV + {12'h0, tn[i], 2'b00}, 1'b1);
			chk("stack", {31'h0, tn[i] < 6'h20}, {31'h0, accept.clear_stack_sel});
		end
		nmi_n <= 1'b0;
		expect_acc("nmi", NMI_VEC, 1'b1);
		chk("nmi level", 32'h7, {29'h0, accept.new_level});
		nmi_n <= 1'b1;
		apb(1'b1, REG_MATCH0, 32'habc0);
		apb(1'b1, REG_CTRL, 32'h3d);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", 32'h3d, rdat);
		fire('{default: '0, fetch: 1'b1, fetch_addr: 20'habc0}, 28'h0);
		expect_acc("match", 20'hfffe8, 1'b1);
		apb(1'b1, REG_CTRL, 32'h0);
		fire('{default: '0, fetch: 1'b1, fetch_addr: 20'habc0}, 28'h0);
		expect_acc("match off", 20'h0, 1'b0);
		apb(1'b1, REG_PRIO_LO, 32'h30000003);
		fire('0, 28'h1);
		expect_acc("ge off", 20'h0, 1'b0);
		apb(1'b1, REG_PEND, 32'h0);
		global_enable <= 1'b1;
		cpl <= 3'h2;
		slow <= 1'b1;
		expect_acc("pend cleared", 20'h0, 1'b0);
		fire('0, 28'h83);
		expect_acc("tie first", BV + 20'h10, 1'b1);
		expect_acc("tie second", BV + 20'h2c, 1'b1);
		expect_acc("level zero", 20'h0, 1'b0);
		apb(1'b1, REG_PEND, 32'h0);
		cpl <= 3'h3;
		fire('0, 28'h1);
		expect_acc("below ipl", 20'h0, 1'b0);
		cpl <= 3'h0;
		expect_acc("held pending", BV + 20'h10, 1'b1);
		// odd base still vectors correctly and is flagged for the slower sequence
		apb(1'b1, REG_BASE, {12'h0, BV} + 32'h1);
		fire('{default: '0, trap: 1'b1, trap_num: 6'h20}, 28'h0);
		expect_acc("odd trap", BV + 20'h81, 1'b1);
		chk("odd base", 32'h1, {31'h0, accept.odd_base});
		end_of_test();
	end
endmodule : tb_interrupt_source_vectoring
